// file: core/flash_power_pkg.sv
package flash_power_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SELECT_AFTER_SUPPLY_DELAY_NS = 30000;
  localparam int WRITE_INHIBIT_DELAY_MIN_MS = 1;
  localparam int WRITE_INHIBIT_DELAY_MAX_MS = 10;
  localparam int DPD_EXIT_DELAY_NS = 3000;
  localparam int DPD_ENTRY_DELAY_NS = 3000;
  localparam int RESET_RECOVERY_TIME_NS = 3000;

  // Least times round up to whole cycles
  localparam int SELECT_AFTER_SUPPLY_CYCLES = (SELECT_AFTER_SUPPLY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_INHIBIT_CYCLES = (WRITE_INHIBIT_DELAY_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DPD_EXIT_CYCLES = (DPD_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DPD_ENTRY_CYCLES = (DPD_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_RECOVERY_CYCLES = (RESET_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int DELAY_W = 12;
  localparam int INHIBIT_W = 20;

  // ------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------
  localparam int CODE_W = 8;
  localparam logic [3:0] BIT_CNT_LAST = 4'h7;
  localparam logic [3:0] BIT_CNT_OVER = 4'h9;
  localparam int SYNC_W = 3;
  localparam int SYNC_SELECT = 0;
  localparam int SYNC_RESET_PIN = 1;
  localparam int SYNC_FRAME_TGL = 2;

  // ------------------------------------------------------------
  // Command codes (plain defaults, adjust per part)
  // ------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h0A;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_PAGE_ERASE = 8'hDB;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OP_SUBSECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
  localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE_DPD = 8'hAB;

  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_DPD_ENTER,
    ST_DPD,
    ST_DPD_EXIT
  } power_state_t;

endpackage

// file: core/sync_two_flop.sv
`timescale 1ns/1ns
module sync_two_flop (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [flash_power_pkg::SYNC_W-1:0] async_i,
  output logic [flash_power_pkg::SYNC_W-1:0] sync_o
);
  import flash_power_pkg::*;

  wire logic [SYNC_W-1:0] hold_w;

  // ------------------------------------------------------------
  // Two stages per bit; the first stage feeds only the second
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_bit
      logic meta_q;
      logic hold_q;
      // Reset to one matches the idle level of the select and reset pins
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_q <= 1'b1;
          hold_q <= 1'b1;
        end else begin
          meta_q <= async_i[g];
          hold_q <= meta_q;
        end
      end
      assign hold_w[g] = hold_q;
    end
  endgenerate

  assign sync_o = hold_w;

endmodule // sync_two_flop

// file: core/flash_power_reset_control.sv
`timescale 1ns/1ns
module flash_power_reset_control #(
  parameter int WRITE_INHIBIT_CYCLES_P = flash_power_pkg::WRITE_INHIBIT_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic select_n_i,
  input wire logic serial_in_i,
  input wire logic reset_pin_n_i,
  input wire logic cycle_busy_i,
  input wire logic status_write_i,
  output logic standby_o,
  output logic deep_power_down_o,
  output logic select_ready_o,
  output logic write_allowed_o,
  output logic in_reset_o,
  output logic busy_flag_o,
  output logic write_latch_flag_o,
  output logic cmd_valid_o,
  output logic [flash_power_pkg::CODE_W-1:0] cmd_code_o,
  output logic abort_cycle_o,
  output logic lock_clear_o
);
  import flash_power_pkg::*;

  // ------------------------------------------------------------
  // Link side, on the serial clock
  // ------------------------------------------------------------
  logic [3:0] bit_cnt_q;
  logic [CODE_W-1:0] shift_q;
  logic [CODE_W-1:0] frame_code_q;
  logic frame_ok_q;
  logic frame_tgl_q;
  wire logic [CODE_W-1:0] shift_next = {shift_q[CODE_W-2:0], serial_in_i};

  // Count restarts with each select; saturates past the code byte
  always_ff @(posedge sclk_i or posedge select_n_i) begin
    if (select_n_i) begin
      bit_cnt_q <= 4'h0;
    end else if (bit_cnt_q != BIT_CNT_OVER) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_q <= 8'h00;
    end else begin
      shift_q <= shift_next;
    end
  end

  // Code and length flag stay frozen while select is high, so the core
  // may read them once the frame toggle has crossed
  always_ff @(posedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_code_q <= 8'h00;
      frame_ok_q <= 1'b0;
      frame_tgl_q <= 1'b0;
    end else begin
      if (bit_cnt_q == BIT_CNT_LAST) begin
        frame_code_q <= shift_next;
      end
      frame_ok_q <= (bit_cnt_q == BIT_CNT_LAST);
      if (bit_cnt_q == 4'h0) begin
        frame_tgl_q <= ~frame_tgl_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Crossing into the core clock
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] sync_w;
  logic select_n_d1_q;
  logic reset_pin_d1_q;
  logic seen_tgl_q;

  sync_two_flop u_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i({frame_tgl_q, reset_pin_n_i, select_n_i}),
    .sync_o(sync_w)
  );

  wire logic sel_n_s = sync_w[SYNC_SELECT];
  wire logic rst_pin_n_s = sync_w[SYNC_RESET_PIN];
  wire logic tgl_s = sync_w[SYNC_FRAME_TGL];
  wire logic frame_end = sel_n_s & ~select_n_d1_q;
  wire logic new_frame = frame_end & (tgl_s != seen_tgl_q);
  wire logic frame_good = new_frame & frame_ok_q;
  wire logic pin_fall = ~rst_pin_n_s & reset_pin_d1_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      select_n_d1_q <= 1'b1;
      reset_pin_d1_q <= 1'b1;
      seen_tgl_q <= 1'b0;
    end else begin
      select_n_d1_q <= sel_n_s;
      reset_pin_d1_q <= rst_pin_n_s;
      if (frame_end) begin
        seen_tgl_q <= tgl_s;
      end
    end
  end

  // ------------------------------------------------------------
  // Power-up delays
  // ------------------------------------------------------------
  logic [DELAY_W-1:0] sel_cnt_q;
  logic [INHIBIT_W-1:0] inh_cnt_q;
  wire logic sel_done = (sel_cnt_q == DELAY_W'(SELECT_AFTER_SUPPLY_CYCLES));
  wire logic inh_done = (inh_cnt_q == INHIBIT_W'(WRITE_INHIBIT_CYCLES_P));

  // counters restart from zero at every power-on reset
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_cnt_q <= '0;
      inh_cnt_q <= '0;
    end else begin
      // select window opens on its own count
      if (!sel_done) begin
        sel_cnt_q <= sel_cnt_q + DELAY_W'(1);
      end
      if (!inh_done) begin
        inh_cnt_q <= inh_cnt_q + INHIBIT_W'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // Reset pin handling
  // ------------------------------------------------------------
  logic pend_reset_q;
  logic [DELAY_W-1:0] rec_cnt_q;
  logic busy_d1_q;
  wire logic busy_fall = busy_d1_q & ~cycle_busy_i;
  wire logic rec_busy = (rec_cnt_q != '0);
  // status write is allowed to finish first
  wire logic status_running = cycle_busy_i & status_write_i;
  wire logic soft_reset = (pin_fall & ~status_running) | (pend_reset_q & ~cycle_busy_i);
  wire logic pin_active = ~rst_pin_n_s | rec_busy;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_reset_q <= 1'b0;
      rec_cnt_q <= '0;
      busy_d1_q <= 1'b0;
    end else begin
      busy_d1_q <= cycle_busy_i;
      if (pin_fall & status_running) begin
        pend_reset_q <= 1'b1;
      end else if (!cycle_busy_i) begin
        pend_reset_q <= 1'b0;
      end
      if (!rst_pin_n_s) begin
        rec_cnt_q <= DELAY_W'(RESET_RECOVERY_CYCLES);
      end else if (rec_busy) begin
        rec_cnt_q <= rec_cnt_q - DELAY_W'(1);
      end
    end
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  power_state_t state_q;
  power_state_t state_d;
  logic [DELAY_W-1:0] dly_cnt_q;
  logic [DELAY_W-1:0] dly_cnt_d;
  logic wel_q;
  logic wel_d;

  wire logic [CODE_W-1:0] code = frame_code_q;
  wire logic is_write_class = (code == OP_WRITE_ENABLE) | (code == OP_PAGE_WRITE) |
                              (code == OP_PAGE_PROGRAM) | (code == OP_PAGE_ERASE) |
                              (code == OP_SECTOR_ERASE);
  wire logic is_modify = is_write_class | (code == OP_SUBSECTOR_ERASE) | (code == OP_BULK_ERASE);
  wire logic accept = frame_good & sel_done & ~pin_active;
  // only the release code passes in deep power-down
  wire logic in_dpd = (state_q == ST_DPD);
  wire logic release_ok = accept & in_dpd & (code == OP_RELEASE_DPD) & ~cycle_busy_i;
  wire logic dpd_ok = accept & (state_q == ST_STANDBY) & (code == OP_DEEP_POWER_DOWN) & ~cycle_busy_i;
  wire logic write_block = is_write_class & ~inh_done;
  // writes ignored once power-down entry is under way
  wire logic fwd_ok = accept & (state_q == ST_STANDBY) & ~write_block &
                      (code != OP_DEEP_POWER_DOWN) & (code != OP_RELEASE_DPD);
  wire logic wel_set = fwd_ok & (code == OP_WRITE_ENABLE);
  wire logic wel_clr = fwd_ok & (code == OP_WRITE_DISABLE);
  wire logic dly_zero = (dly_cnt_q == '0);

  always_comb begin
    state_d = state_q;
    dly_cnt_d = dly_zero ? dly_cnt_q : dly_cnt_q - DELAY_W'(1);
    case (state_q)
      ST_STANDBY: begin
        if (dpd_ok) begin
          state_d = ST_DPD_ENTER;
          dly_cnt_d = DELAY_W'(DPD_ENTRY_CYCLES);
        end
      end
      // entry takes effect after its delay
      ST_DPD_ENTER: begin
        if (dly_zero) begin
          state_d = ST_DPD;
        end
      end
      ST_DPD: begin
        // a running cycle blocks the release
        if (release_ok) begin
          state_d = ST_DPD_EXIT;
          dly_cnt_d = DELAY_W'(DPD_EXIT_CYCLES);
        end
      end
      ST_DPD_EXIT: begin
        if (dly_zero) begin
          state_d = ST_STANDBY;
        end
      end
      default: begin
        state_d = ST_STANDBY;
      end
    endcase
    if (soft_reset) begin
      state_d = ST_STANDBY;
      dly_cnt_d = '0;
    end
  end

  // latch set by write enable; set wins over cycle-end clear
  always_comb begin
    wel_d = wel_q;
    if (wel_clr | busy_fall) begin
      wel_d = 1'b0;
    end
    if (wel_set) begin
      wel_d = 1'b1;
    end
    if (soft_reset) begin
      wel_d = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_STANDBY;
      dly_cnt_q <= '0;
      wel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      dly_cnt_q <= dly_cnt_d;
      wel_q <= wel_d;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      standby_o <= 1'b1;
      deep_power_down_o <= 1'b0;
      select_ready_o <= 1'b0;
      write_allowed_o <= 1'b0;
      in_reset_o <= 1'b0;
      busy_flag_o <= 1'b0;
      write_latch_flag_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_code_o <= 8'h00;
      abort_cycle_o <= 1'b0;
      lock_clear_o <= 1'b0;
    end else begin
      standby_o <= (state_d == ST_STANDBY);
      deep_power_down_o <= (state_d == ST_DPD);
      select_ready_o <= sel_done & ~pin_active & (state_d != ST_DPD_EXIT);
      write_allowed_o <= inh_done & sel_done;
      in_reset_o <= pin_active;
      busy_flag_o <= cycle_busy_i;
      write_latch_flag_o <= wel_d;
      // Modify commands other than write enable need the latch; the engine also checks protection
      cmd_valid_o <= fwd_ok & (~is_modify | (code == OP_WRITE_ENABLE) | wel_q);
      if (fwd_ok) begin
        cmd_code_o <= code;
      end
      // the reset that follows returns to standby and clears the latch, but does not restart the power-up counts
      abort_cycle_o <= pin_fall & cycle_busy_i & ~status_write_i;
      lock_clear_o <= pin_fall;
    end
  end

endmodule // flash_power_reset_control

// file: testbench/flash_power_asserts.sv
`timescale 1ns/1ns
module flash_power_asserts
  import flash_power_pkg::*;
#(
  parameter int WRITE_INHIBIT_CYCLES_P = WRITE_INHIBIT_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic reset_pin_n_i,
  input wire logic status_write_i,
  input wire logic standby_o,
  input wire logic deep_power_down_o,
  input wire logic select_ready_o,
  input wire logic write_allowed_o,
  input wire logic in_reset_o,
  input wire logic cmd_valid_o,
  input wire logic [CODE_W-1:0] cmd_code_o,
  input wire logic abort_cycle_o,
  input wire logic lock_clear_o
);
  // ------------------------------------------------------------
  // Cycle counters
  // ------------------------------------------------------------
  logic [23:0] up_q;
  logic [9:0] gap_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      up_q <= '0;
      gap_q <= '0;
    end else begin
      up_q <= (up_q == 24'hFFFFFF) ? up_q : up_q + 24'h000001;
      gap_q <= (standby_o || deep_power_down_o) ? 10'h000 : gap_q + 10'h001;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  pin_clear_a:
  assert property ($fell(reset_pin_n_i) |-> ##[3:5] lock_clear_o) else $error("no lock clear after reset pin");
  abort_lock_a:
  assert property (abort_cycle_o |-> lock_clear_o) else $error("abort without lock clear");
  status_keep_a:
  assert property (abort_cycle_o |-> !$past(status_write_i)) else $error("status write aborted");
  dpd_only_a:
  assert property (deep_power_down_o |-> !cmd_valid_o) else $error("command in dpd");
  wren_gate_a:
  assert property (cmd_valid_o && cmd_code_o == OP_WRITE_ENABLE |-> write_allowed_o) else $error("early write enable");
  exit_delay_a:
  assert property ($rose(standby_o) && !in_reset_o |-> gap_q >= DPD_EXIT_CYCLES) else $error("dpd exit too fast");
  entry_delay_a:
  assert property ($rose(deep_power_down_o) |-> gap_q >= DPD_ENTRY_CYCLES) else $error("dpd entry too fast");
  por_ready_a:
  assert property (select_ready_o |-> up_q >= SELECT_AFTER_SUPPLY_CYCLES) else $error("select ready too soon");
  inhibit_a:
  assert property (write_allowed_o |-> up_q >= WRITE_INHIBIT_CYCLES_P) else $error("write allowed too soon");
  cover property ($rose(deep_power_down_o));
  cover property (abort_cycle_o);
  cover property ($rose(standby_o) && !in_reset_o);
endmodule // flash_power_asserts

bind flash_power_reset_control flash_power_asserts #(.WRITE_INHIBIT_CYCLES_P(WRITE_INHIBIT_CYCLES_P)) checker_i (
  .clock_i, .reset_n_i, .reset_pin_n_i, .status_write_i, .standby_o, .deep_power_down_o, .select_ready_o,
  .write_allowed_o, .in_reset_o, .cmd_valid_o, .cmd_code_o, .abort_cycle_o, .lock_clear_o);

// file: testbench/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
  output logic sclk_o,
  output logic select_n_o,
  output logic serial_o
);
  // Link clock stands still low outside frames
  initial begin
    sclk_o = 1'b0;
    select_n_o = 1'b1;
    serial_o = 1'b1;
  end
  task automatic send(input logic [7:0] code, input int extra);
    int i;
    select_n_o = 1'b0;
    for (i = 0; i < 8 + extra; i++) begin
      serial_o = (i < 8) ? code[7-i] : ~serial_o;
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    #6 select_n_o = 1'b1;
    // Released line shows no stale bit
    serial_o = ~serial_o;
  endtask
endmodule // spi_host_model

// file: testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import flash_power_pkg::*;
  logic clock_i = 1'b0, reset_n_i = 1'b0, reset_pin_n_i = 1'b1, cycle_busy_i = 1'b0, status_write_i = 1'b0;
  logic sclk_i, select_n_i, serial_in_i, standby_o, deep_power_down_o, select_ready_o, write_allowed_o;
  logic in_reset_o, busy_flag_o, write_latch_flag_o, cmd_valid_o, abort_cycle_o, lock_clear_o;
  logic [CODE_W-1:0] cmd_code_o;
  int mismatches = 0, samples_checked = 0, cycles = 0, n_lock = 0, n_abort = 0, n_cmd = 0;
  always #4 clock_i = ~clock_i;
  spi_host_model host (.sclk_o(sclk_i), .select_n_o(select_n_i), .serial_o(serial_in_i));
  flash_power_reset_control #(.WRITE_INHIBIT_CYCLES_P(50)) uut (.clock_i, .reset_n_i, .sclk_i, .select_n_i,
    .serial_in_i, .reset_pin_n_i, .cycle_busy_i, .status_write_i, .standby_o, .deep_power_down_o, .select_ready_o,
    .write_allowed_o, .in_reset_o, .busy_flag_o, .write_latch_flag_o, .cmd_valid_o, .cmd_code_o, .abort_cycle_o,
    .lock_clear_o);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Pulses last one cycle, so they are counted as they pass
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (lock_clear_o === 1'b1) n_lock <= n_lock + 1;
    if (abort_cycle_o === 1'b1) n_abort <= n_abort + 1;
    if (cmd_valid_o === 1'b1) n_cmd <= n_cmd + 1;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic frame(input logic [7:0] code, input int extra);
    @(negedge clock_i);
    host.send(code, extra);
    idle(8);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_power_up;
    int i;
    reset_n_i = 1'b0;
    reset_pin_n_i = 1'b0;
    idle(5);
    check(standby_o, 1'b1, "standby in reset");
    check(write_latch_flag_o, 1'b0, "latch in reset");
    frame(OP_WRITE_ENABLE, 0);
    check(cmd_valid_o | write_latch_flag_o, 1'b0, "frame taken in reset");
    reset_n_i = 1'b1;
    reset_pin_n_i = 1'b1;
    idle(2);
    check(deep_power_down_o | busy_flag_o, 1'b0, "power-up state");
    frame(OP_WRITE_ENABLE, 0);
    check(write_latch_flag_o, 1'b0, "frame before select delay");
    for (i = 0; i < 5000 && select_ready_o !== 1'b1; i++) idle(1);
    check(i > SELECT_AFTER_SUPPLY_CYCLES - 100 && i < SELECT_AFTER_SUPPLY_CYCLES, 1'b1, "select ready time");
    idle(4);
    check(write_allowed_o, 1'b1, "writes allowed");
  endtask
  task automatic t_wren;
    int c0;
    c0 = n_cmd;
    frame(OP_WRITE_ENABLE, 0);
    check(write_latch_flag_o, 1'b1, "latch set");
    check(n_cmd == c0 + 1, 1'b1, "command pulse");
    check(cmd_code_o == OP_WRITE_ENABLE, 1'b1, "command code");
  endtask
  task automatic t_dpd;
    frame(OP_DEEP_POWER_DOWN, 0);
    check(deep_power_down_o | standby_o, 1'b0, "entry delay");
    idle(380);
    check(deep_power_down_o, 1'b1, "dpd entered");
    frame(OP_WRITE_DISABLE, 0);
    check(write_latch_flag_o, 1'b1, "command in dpd");
    frame(OP_RELEASE_DPD, 1);
    check(deep_power_down_o, 1'b1, "release with extra clock");
    frame(OP_RELEASE_DPD, 0);
    check(deep_power_down_o | standby_o, 1'b0, "release taken");
    idle(360);
    check(standby_o, 1'b0, "release delay");
    idle(20);
    check(standby_o, 1'b1, "standby after release");
  endtask
  task automatic t_busy_release;
    int a0;
    frame(OP_DEEP_POWER_DOWN, 0);
    idle(380);
    cycle_busy_i = 1'b1;
    idle(2);
    a0 = n_abort;
    check(busy_flag_o, 1'b1, "busy flag");
    frame(OP_RELEASE_DPD, 0);
    idle(380);
    check(deep_power_down_o, 1'b1, "release while busy");
    check(n_abort == a0, 1'b1, "cycle disturbed");
    cycle_busy_i = 1'b0;
    frame(OP_RELEASE_DPD, 0);
    idle(390);
    check(standby_o, 1'b1, "release after cycle");
  endtask
  task automatic t_pin_abort;
    int a0, l0, c0;
    a0 = n_abort;
    l0 = n_lock;
    cycle_busy_i = 1'b1;
    reset_pin_n_i = 1'b0;
    idle(8);
    check(n_abort == a0 + 1, 1'b1, "abort pulse");
    check(n_lock == l0 + 1, 1'b1, "lock clear");
    check(write_latch_flag_o, 1'b0, "latch cleared");
    check(in_reset_o & ~select_ready_o, 1'b1, "reset state");
    cycle_busy_i = 1'b0;
    reset_pin_n_i = 1'b1;
    idle(368);
    check(in_reset_o, 1'b1, "recovery time");
    idle(24);
    check(select_ready_o & ~in_reset_o, 1'b1, "ready after recovery");
    c0 = n_cmd;
    frame(OP_PAGE_PROGRAM, 0);
    check(n_cmd == c0, 1'b1, "program without latch");
  endtask
  task automatic t_pin_status;
    int a0, l0;
    frame(OP_DEEP_POWER_DOWN, 0);
    idle(380);
    cycle_busy_i = 1'b1;
    status_write_i = 1'b1;
    idle(2);
    a0 = n_abort;
    l0 = n_lock;
    reset_pin_n_i = 1'b0;
    idle(8);
    check(n_abort == a0, 1'b1, "status write aborted");
    check(n_lock == l0 + 1, 1'b1, "lock clear");
    check(write_latch_flag_o & deep_power_down_o, 1'b1, "reset not deferred");
    reset_pin_n_i = 1'b1;
    idle(4);
    cycle_busy_i = 1'b0;
    status_write_i = 1'b0;
    idle(6);
    check(standby_o & ~write_latch_flag_o, 1'b1, "reset after status write");
    idle(400);
  endtask
  initial begin
    t_power_up();
    t_wren();
    t_dpd();
    t_busy_release();
    t_wren();
    t_pin_abort();
    t_wren();
    t_pin_status();
    t_wren();
    t_power_up();
    conclude();
  end
endmodule // testbench
